// [testbench/config_punch_through_tb.sv]
// Self-checking bench for the indirect configuration access unit
`timescale 1ns/1ps
`default_nettype none
module config_punch_through_tb;
    typedef struct packed {
        logic [31:0] c;
        logic [31:0] d;
        logic [3:0]  s;
        logic [2:0]  k;
        logic [31:0] r;
    } cpt_row_s;
    logic              pclk = 0;
    logic              presetn = 0;
    logic              hot_rst_n = 1;
    logic              psel = 0;
    logic              penable = 0;
    logic              pwrite = 0;
    logic [11:0]       paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [3:0]        pstrb = '0;
    logic [31:0]       prdata;
    logic              pready, pslverr, req_valid, req_ready, req_abort, cpl_valid, irq;
    cpt_pkg::cpt_req_s req_out, last_req, g, er;
    cpt_pkg::cpt_cpl_s cpl_in;
    logic [3:0]        dly = 4'h2;
    logic              hang = 0;
    cpt_pkg::cpt_cpl_e code = cpt_pkg::CPL_SC;
    logic [31:0]       rdata = '0;
    logic [31:0]       rd;
    logic [7:0]        n_acc, na;
    logic              se, iq;
    int                err_total = 0;
    int                tests_run = 0;
    // Reads with partial lanes, full-lane writes, codes 0 to 3, both types, field extremes
    cpt_row_s rows [4] = '{
        '{32'h0000_0004, 32'h1234_5678, 4'h5, 3'h0, 32'hcafe_0001},
        '{32'hc000_0000, 32'ha5a5_5a5a, 4'hf, 3'h1, 32'h0},
        '{32'h4fff_fffc, 32'h0, 4'h8, 3'h2, 32'h0bad_f00d},
        '{32'hffff_ffff, 32'h600d_0001, 4'hf, 3'h3, 32'h0}};

    always #25 pclk = ~pclk;

    cpt_unit dut (.pclk(pclk), .presetn(presetn), .hot_rst_n(hot_rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
        .req_out(req_out), .req_ready(req_ready), .req_abort(req_abort),
        .cpl_valid(cpl_valid), .cpl_in(cpl_in), .irq(irq));
    cpt_far_model far (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
        .req_out(req_out), .req_ready(req_ready), .req_abort(req_abort),
        .cpl_valid(cpl_valid), .cpl_in(cpl_in), .dly(dly), .hang(hang), .code(code),
        .rdata(rdata), .last_req(last_req), .n_acc(n_acc));

    task automatic chk(input logic [31:0] v, input logic [31:0] e, input string m);
        tests_run++;
        if (v !== e) begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, v, e);
        end
    endtask
    task automatic chk_req(input cpt_pkg::cpt_req_s v, input cpt_pkg::cpt_req_s e);
        tests_run++;
        if (v !== e) begin
            err_total++;
            $display("BAD t=%0t request got %h exp %h", $time, v, e);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d of %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Answer taken at the access edge, before that edge's updates land
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int   n;
        logic ok;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            ok = pready;
            rd = prdata;
            se = pslverr;
            iq = irq;
        end while (ok !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (ok !== 1'b1) begin
            err_total++;
            test_done();
        end
        @(posedge pclk);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            apb(0, cpt_pkg::ADDR_STATUS, 0, 0);
            n++;
        end while (rd[1] !== 1'b1 && n < 30);
        if (rd[1] !== 1'b1) begin
            err_total++;
            test_done();
        end
    endtask
    task automatic rst_chk;
        apb(0, cpt_pkg::ADDR_CTRL, 0, 0);
        chk(rd, 32'h0, "ctrl reset");
        apb(0, cpt_pkg::ADDR_DATA, 0, 0);
        chk(rd, 32'h0, "data reset");
        apb(0, cpt_pkg::ADDR_STATUS, 0, 0);
        chk(rd, 32'h8000_0000, "status reset");
        apb(0, 12'h0fc, 0, 0);
        chk({se, rd[30:0]}, 32'h8000_0000, "unmapped");
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_chk();
        foreach (rows[i]) begin
            code <= cpt_pkg::cpt_cpl_e'(rows[i].k);
            rdata <= rows[i].r;
            apb(1, cpt_pkg::ADDR_CTRL, rows[i].c, 4'hf);
            apb(0, cpt_pkg::ADDR_CTRL, 0, 0);
            chk(rd, rows[i].c & 32'hcfff_fffc, "ctrl");
            apb(1, cpt_pkg::ADDR_DATA, rows[i].d, rows[i].s);
            wait_done();
            chk(rd, 32'h8000_0002 | {27'h0, rows[i].k, 2'h0}, "status");
            apb(0, cpt_pkg::ADDR_DATA, 0, 0);
            chk(rd, rows[i].c[31] ? rows[i].d : rows[i].r, "data");
            er = {rows[i].c[31:30], rows[i].c[27:2], rows[i].s,
                  rows[i].c[31] ? rows[i].d : 32'h0};
            g = last_req;
            if (!rows[i].c[31]) g.wdata = '0;
            chk_req(g, er);
        end
        // Slow far side: busy shows at once, a second write launches nothing
        dly <= 4'h6;
        na = n_acc;
        apb(1, cpt_pkg::ADDR_DATA, 32'h0, 4'hf);
        apb(0, cpt_pkg::ADDR_STATUS, 0, 0);
        chk(rd & 32'h3, 32'h1, "busy");
        apb(1, cpt_pkg::ADDR_DATA, 32'h1, 4'hf);
        wait_done();
        chk({24'h0, n_acc}, {24'h0, na + 8'h1}, "launches");
        chk(rd & 32'h1, 32'h0, "idle");
        // Abort of a request the far side never answers
        dly <= 4'h2;
        hang <= 1'b1;
        code <= cpt_pkg::CPL_SC;
        na = n_acc;
        apb(1, cpt_pkg::ADDR_DATA, 32'h600d_0001, 4'hf);
        apb(1, cpt_pkg::ADDR_STATUS, 32'h2, 4'hf);
        hang <= 1'b0;
        wait_done();
        chk(rd, 32'h8000_0032, "abort");
        chk({24'h0, n_acc}, {24'h0, na}, "aborted accept");
        apb(1, cpt_pkg::ADDR_DATA, 32'h600d_0001, 4'hf);
        wait_done();
        chk(rd, 32'h8000_0002, "abort gone");
        // Interrupt enable, mask and clear
        apb(1, cpt_pkg::ADDR_IRQ_EN, 32'h2, 4'hf);
        apb(0, cpt_pkg::ADDR_STATUS, 0, 0);
        chk({31'h0, iq}, 32'h1, "irq on");
        apb(1, cpt_pkg::ADDR_IRQ_EN, 32'h0, 4'hf);
        apb(0, cpt_pkg::ADDR_STATUS, 0, 0);
        chk({31'h0, iq}, 32'h0, "irq masked");
        apb(1, cpt_pkg::ADDR_IRQ_EN, 32'h2, 4'hf);
        apb(1, cpt_pkg::ADDR_STATUS, 32'h2, 4'hf);
        apb(0, cpt_pkg::ADDR_STATUS, 0, 0);
        chk({rd[1], 30'h0, iq}, 32'h0, "clear");
        // Hot reset keeps control and data but clears the type bit
        apb(1, cpt_pkg::ADDR_CTRL, 32'h4123_4568, 4'hf);
        hot_rst_n <= 1'b0;
        repeat (2) @(posedge pclk);
        hot_rst_n <= 1'b1;
        @(posedge pclk);
        apb(0, cpt_pkg::ADDR_CTRL, 0, 0);
        chk(rd, 32'h0123_4568, "hot ctrl");
        apb(0, cpt_pkg::ADDR_DATA, 0, 0);
        chk(rd, 32'h600d_0001, "hot data");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_chk();
        test_done();
    end
endmodule
`default_nettype wire

// [testbench/cpt_far_model.sv]
// Far-side configuration target model
`timescale 1ns/1ps
`default_nettype none
module cpt_far_model (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Request side
    input  wire logic              req_valid,
    input  wire cpt_pkg::cpt_req_s req_out,
    output logic                   req_ready,
    input  wire logic              req_abort,
    // Completion side
    output logic                   cpl_valid,
    output cpt_pkg::cpt_cpl_s      cpl_in,
    // Bench controls
    input  wire logic [3:0]        dly,
    input  wire logic              hang,
    input  wire cpt_pkg::cpt_cpl_e code,
    input  wire logic [31:0]       rdata,
    output cpt_pkg::cpt_req_s      last_req,
    output logic [7:0]             n_acc
);
    logic       pend_ff;
    logic [3:0] cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff   <= 1'b0;
            cnt_ff    <= 4'h0;
            req_ready <= 1'b0;
            cpl_valid <= 1'b0;
            cpl_in    <= '0;
            last_req  <= '0;
            n_acc     <= 8'h0;
        end else begin
            req_ready    <= 1'b0;
            cpl_valid    <= 1'b0;
            // Idle data toggles so a stale word never passes as valid
            cpl_in.rdata <= ~cpl_in.rdata;
            if (req_abort) begin
                pend_ff <= 1'b0;
                cnt_ff  <= 4'h0;
            end else if ((req_valid && !req_ready && !pend_ff) || (pend_ff && !hang)) begin
                cnt_ff <= cnt_ff + 4'h1;
                if (cnt_ff == dly) begin
                    cnt_ff  <= 4'h0;
                    pend_ff <= !pend_ff;
                    if (pend_ff) begin
                        cpl_valid <= 1'b1;
                        cpl_in    <= {code, rdata};
                    end else begin
                        req_ready <= 1'b1;
                        last_req  <= req_out;
                        n_acc     <= n_acc + 8'h1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/cpt_pkg.sv]
// Package for the indirect configuration access unit
package cpt_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL   = 12'h0a0;
    localparam logic [11:0] ADDR_DATA   = 12'h0a4;
    localparam logic [11:0] ADDR_STATUS = 12'h0a8;
    localparam logic [11:0] ADDR_IRQ_EN = 12'h0c0;

    // ----------------------------------------------------------------
    // Control field positions
    // ----------------------------------------------------------------
    localparam int REG_LSB   = 2;
    localparam int REG_MSB   = 7;
    localparam int EXT_REG_LSB = 8;
    localparam int EXT_REG_MSB = 11;
    localparam int FN_LSB      = 12;
    localparam int FN_MSB      = 14;
    localparam int DEVNUM_LSB  = 15;
    localparam int DEVNUM_MSB  = 19;
    localparam int BUS_LSB   = 20;
    localparam int BUS_MSB   = 27;
    localparam int TYPE_BIT  = 30;
    localparam int OP_BIT    = 31;

    // ----------------------------------------------------------------
    // Status field positions and values
    // ----------------------------------------------------------------
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_DONE_BIT  = 1;
    localparam int ST_CODE_LSB  = 2;
    localparam int ST_CODE_MSB  = 4;
    localparam int ST_ABORT_BIT = 5;
    localparam int ST_CAP_BIT   = 31;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'hcfff_fffc;

    // ----------------------------------------------------------------
    // Completion codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CPL_SC  = 3'h0,
        CPL_UR  = 3'h1,
        CPL_CRS = 3'h2,
        CPL_CA  = 3'h3,
        CPL_RA  = 3'h4
    } cpt_cpl_e;

    // Unit state, Gray coded along idle and wait
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1
    } cpt_state_e;

    // Outgoing configuration request
    typedef struct packed {
        logic        is_write;
        logic        type1;
        logic [7:0]  bus;
        logic [4:0]  devnum;
        logic [2:0]  fnnum;
        logic [3:0]  ext_reg;
        logic [5:0]  regnum;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cpt_req_s;

    // Returned completion
    typedef struct packed {
        cpt_cpl_e    status;
        logic [31:0] rdata;
    } cpt_cpl_s;

endpackage

// [verilog/cpt_unit.sv]
// Indirect configuration access unit with APB register slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Control bits 7:2 hold the dword register index of the request.
// - Control bits 11:8 hold the extended register index of the request.
// - Control bits 14:12 hold the function number of the request.
// - Control bits 19:15 hold the device number of the request.
// - Control bits 27:20 hold the bus number of the request.
// - Control bit 30 selects a type 0 or type 1 configuration request.
// - Control bit 31 selects a configuration read or write for the launch.
// - Each write to the data register while idle and out of hot reset issues one configuration request.
// - The request byte enables equal the byte enables of that data write.
// - For a write the data register value is the request payload.
// - For a read the written value is dropped and completion data loads later.
// - Outcome is reported through the status register; done also drives irq when the interrupt is enabled.
// - Address, operation and data fields clear only at power-up, not at hot reset.
// - Busy reads one while a request is outstanding and zero when idle.
// - Done sets on completion, and writing one clears it or aborts a request.
// - Completion codes are success 0, unsupported 1, retry 2, completer 3, requester 4.
module cpt_unit (
    // APB slave
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                hot_rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Far side configuration request
    output logic                     req_valid,
    output cpt_pkg::cpt_req_s        req_out,
    input  wire logic                req_ready,
    output logic                     req_abort,
    // Far side completion
    input  wire logic                cpl_valid,
    input  wire cpt_pkg::cpt_cpl_s   cpl_in,
    // Interrupt
    output logic                     irq
);

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic wr_acc;
    logic rd_acc;
    logic hit_ctrl;
    logic hit_data;
    logic hit_stat;
    logic hit_irq;
    logic launch;
    logic abort_req;

    assign wr_acc   = psel & penable & pwrite;
    assign rd_acc   = psel & penable & ~pwrite;
    assign hit_ctrl = (paddr == cpt_pkg::ADDR_CTRL);
    assign hit_data = (paddr == cpt_pkg::ADDR_DATA);
    assign hit_stat = (paddr == cpt_pkg::ADDR_STATUS);
    assign hit_irq  = (paddr == cpt_pkg::ADDR_IRQ_EN);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~(hit_ctrl | hit_data | hit_stat | hit_irq);

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0]         ctrl_ff;
    logic                type_ff;
    logic [31:0]         data_ff;
    cpt_pkg::cpt_state_e state_ff;
    logic                done_ff;
    logic [2:0]          code_ff;
    logic                abort_ff;
    logic                irq_en_ff;
    logic                req_pend_ff;
    cpt_pkg::cpt_req_s   req_ff;

    // Launch only from idle; a write while busy still updates data for a write operation but issues nothing
    // No launch during hot reset, else a request would hang with the unit idle
    assign launch    = wr_acc & hit_data & (state_ff == cpt_pkg::ST_IDLE) & hot_rst_n;
    assign abort_req = wr_acc & hit_stat & pwdata[cpt_pkg::ST_DONE_BIT];

    // power-up only fields
    // Power-up reset only; hot reset leaves these untouched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= cpt_pkg::CTRL_RESET;
        end else if (wr_acc & hit_ctrl) begin
            ctrl_ff <= lane_merge(ctrl_ff, pwdata, pstrb) & cpt_pkg::CTRL_WMASK;
        end
    end

    // type bit
    // Type bit also clears on hot reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            type_ff <= 1'b0;
        end else if (!hot_rst_n) begin
            type_ff <= 1'b0;
        end else if (wr_acc & hit_ctrl & pstrb[cpt_pkg::TYPE_BIT / 8]) begin
            type_ff <= pwdata[cpt_pkg::TYPE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ff <= cpt_pkg::DATA_RESET;
        end else if (state_ff == cpt_pkg::ST_WAIT && cpl_valid && !req_pend_ff
                     && !req_ff.is_write) begin
            data_ff <= cpl_in.rdata;
        end else if (wr_acc & hit_data & ctrl_ff[cpt_pkg::OP_BIT]) begin
            data_ff <= lane_merge(data_ff, pwdata, pstrb);
        end
    end

    // ----------------------------------------------------------------
    // Request sequencing
    // ----------------------------------------------------------------
    // launch and busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= cpt_pkg::ST_IDLE;
        end else if (!hot_rst_n) begin
            state_ff <= cpt_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                cpt_pkg::ST_IDLE: begin
                    if (launch) begin
                        state_ff <= cpt_pkg::ST_WAIT;
                    end
                end
                cpt_pkg::ST_WAIT: begin
                    if (abort_req || (cpl_valid && !req_pend_ff)) begin
                        state_ff <= cpt_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= cpt_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_pend_ff <= 1'b0;
            req_ff      <= '0;
        end else if (launch) begin
            req_pend_ff    <= 1'b1;
            req_ff.is_write <= ctrl_ff[cpt_pkg::OP_BIT];
            req_ff.type1   <= type_ff;
            req_ff.bus     <= ctrl_ff[cpt_pkg::BUS_MSB:cpt_pkg::BUS_LSB];
            req_ff.devnum  <= ctrl_ff[cpt_pkg::DEVNUM_MSB:cpt_pkg::DEVNUM_LSB];
            req_ff.fnnum   <= ctrl_ff[cpt_pkg::FN_MSB:cpt_pkg::FN_LSB];
            req_ff.ext_reg <= ctrl_ff[cpt_pkg::EXT_REG_MSB:cpt_pkg::EXT_REG_LSB];
            req_ff.regnum  <= ctrl_ff[cpt_pkg::REG_MSB:cpt_pkg::REG_LSB];
            req_ff.byte_en <= pstrb;
            req_ff.wdata   <= lane_merge(data_ff, pwdata, pstrb);
        end else if (req_ready || abort_req || !hot_rst_n) begin
            req_pend_ff <= 1'b0;
        end
    end

    assign req_valid = req_pend_ff;
    assign req_out   = req_ff;
    assign req_abort = abort_req & (state_ff == cpt_pkg::ST_WAIT);

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    // completion status
    // Completion wins over a same-cycle abort so no outcome is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff  <= 1'b0;
            code_ff  <= cpt_pkg::CPL_SC;
            abort_ff <= 1'b0;
        end else if (state_ff == cpt_pkg::ST_WAIT && cpl_valid && !req_pend_ff) begin
            done_ff  <= 1'b1;
            code_ff  <= cpl_in.status;
            abort_ff <= (cpl_in.status == cpt_pkg::CPL_RA);
        end else if (state_ff == cpt_pkg::ST_WAIT && abort_req) begin
            done_ff  <= 1'b1;
            code_ff  <= cpt_pkg::CPL_RA;
            abort_ff <= 1'b1;
        end else if (launch) begin
            done_ff  <= 1'b0;
            abort_ff <= 1'b0;
        end else if (abort_req) begin
            done_ff  <= 1'b0;
        end
    end

    // Interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_ff <= 1'b0;
        end else if (wr_acc & hit_irq & pstrb[cpt_pkg::ST_DONE_BIT / 8]) begin
            irq_en_ff <= pwdata[cpt_pkg::ST_DONE_BIT];
        end
    end

    assign irq = done_ff & irq_en_ff;

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // register readback
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_acc) begin
            if (hit_ctrl) begin
                prdata = ctrl_ff;
                prdata[cpt_pkg::TYPE_BIT] = type_ff;
            end else if (hit_data) begin
                prdata = data_ff;
            end else if (hit_stat) begin
                prdata[cpt_pkg::ST_BUSY_BIT] = (state_ff == cpt_pkg::ST_WAIT);
                prdata[cpt_pkg::ST_DONE_BIT] = done_ff;
                prdata[cpt_pkg::ST_CODE_MSB:cpt_pkg::ST_CODE_LSB] = code_ff;
                prdata[cpt_pkg::ST_ABORT_BIT] = abort_ff;
                prdata[cpt_pkg::ST_CAP_BIT] = 1'b1;
            end else if (hit_irq) begin
                prdata[cpt_pkg::ST_DONE_BIT] = irq_en_ff;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_launch_busy: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch && hot_rst_n |=> state_ff == cpt_pkg::ST_WAIT && !done_ff)
        else $error("launch did not set busy");
    a_req_bytes: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch |=> req_valid && req_out.byte_en == $past(pstrb))
        else $error("byte enables mismatch");
    a_req_op: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch |=> req_out.is_write == $past(ctrl_ff[cpt_pkg::OP_BIT]))
        else $error("operation mismatch");
    a_req_bus: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch |=> req_out.bus == $past(ctrl_ff[cpt_pkg::BUS_MSB:cpt_pkg::BUS_LSB]))
        else $error("bus field mismatch");
    a_cpl_done: assert property (
        @(posedge pclk) disable iff (!presetn || !hot_rst_n)
        state_ff == cpt_pkg::ST_WAIT && cpl_valid && !req_pend_ff
        |=> done_ff && state_ff == cpt_pkg::ST_IDLE)
        else $error("completion not flagged");
    a_rd_return: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_ff == cpt_pkg::ST_WAIT && cpl_valid && !req_pend_ff
        && !req_out.is_write |=> data_ff == $past(cpl_in.rdata))
        else $error("read data not loaded");
    a_ra_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        done_ff |-> abort_ff == (code_ff == cpt_pkg::CPL_RA))
        else $error("abort flag inconsistent");
    a_hot_keep: assert property (
        @(posedge pclk) disable iff (!presetn)
        !hot_rst_n && !(wr_acc && hit_ctrl) |=> $stable(ctrl_ff))
        else $error("control lost on hot reset");
    a_abort_end: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_ff == cpt_pkg::ST_WAIT && abort_req && !(cpl_valid && !req_pend_ff)
        |=> done_ff && abort_ff && code_ff == cpt_pkg::CPL_RA)
        else $error("abort not flagged");
    a_w1c_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_ff == cpt_pkg::ST_IDLE && abort_req && !launch |=> !done_ff)
        else $error("done not cleared");
    a_hot_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        !hot_rst_n |=> state_ff == cpt_pkg::ST_IDLE && !req_valid)
        else $error("hot reset left request");
    a_read_keep: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && hit_data && !ctrl_ff[cpt_pkg::OP_BIT]
        && !(state_ff == cpt_pkg::ST_WAIT && cpl_valid && !req_pend_ff)
        |=> $stable(data_ff))
        else $error("read launch changed data");

endmodule

`default_nettype wire
